/* prs_defs.svh */
// prs_defs.svh: offsets, field positions, reset values and timing counts
// of the resource sequencer; definitions only, included by the design.
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// clock figures
`define PRS_MCLK_FREQ_HZ   100000000
`define PRS_LPO_FREQ_HZ    32768
`define PRS_LPO_DIV        (`PRS_MCLK_FREQ_HZ / `PRS_LPO_FREQ_HZ)

// register byte offsets
`define PRS_OFF_CTRL       8'h00
`define PRS_OFF_MINMASK    8'h04
`define PRS_OFF_STATUS     8'h08
`define PRS_OFF_RES_ON     8'h0c
`define PRS_OFF_RES_PEND   8'h10
`define PRS_OFF_REQUIRED   8'h14
`define PRS_OFF_SEL        8'h18
`define PRS_OFF_TIME_ON    8'h1c
`define PRS_OFF_TIME_OFF   8'h20
`define PRS_OFF_DEPMASK    8'h24
`define PRS_OFF_CLKMAP     8'h28
`define PRS_OFF_RTMR_CNT   8'h2c
`define PRS_OFF_RTMR_MASK  8'h30

// control fields
`define PRS_CTRL_CMD_LSB   0
`define PRS_CTRL_RATE_LSB  2

// mode commands
`define PRS_CMD_NONE       2'h0
`define PRS_CMD_DOZE       2'h1
`define PRS_CMD_DEEP       2'h2
`define PRS_CMD_DOWN       2'h3

// reset values
`define PRS_RST_MINMASK    32'h0000_0001
`define PRS_RST_RATE       2'h3
`endif

/* prs_pkg.sv */
// prs_pkg.sv: types of the resource sequencer.
// assumes prs_defs.svh holds the numeric constants.
package prs_pkg;

   // {in transition, on}: exactly four resource states
   typedef enum logic [1:0] {
      RS_OFF  = 2'b00,
      RS_ON   = 2'b01,
      RS_UP   = 2'b10,
      RS_DOWN = 2'b11
   } prs_res_state_t;

   typedef enum logic [2:0] {
      PM_ACTIVE  = 3'b000,
      PM_DOZE    = 3'b001,
      PM_SAVE    = 3'b010,
      PM_DEEP    = 3'b011,
      PM_RESTORE = 3'b100,
      PM_DOWN    = 3'b101
   } prs_mode_t;

endpackage : prs_pkg

/* prs_sequencer.sv */
// prs_sequencer.sv: resource sequencer and power-mode control, one clock.
// assumes inputs synchronous to mclk and a plain register port master.
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_sequencer
   import prs_pkg::*;
#(
   parameter int NRES   = 8,
   parameter int TW     = 8,
   parameter int NCLK   = 4,
   parameter int NTMR   = 2,
   parameter int RTW    = 16,
   parameter int LP_DIV = `PRS_LPO_DIV
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // regulator power-on pin
   input  wire logic             reg_on,
   // register port
   input  wire logic [7:0]       addr,
   input  wire logic [31:0]      wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [31:0]      rdata,
   // requests and wake events
   input  wire logic [NCLK-1:0]  clk_req,
   input  wire logic             wake_irq,
   input  wire logic             usb_resume,
   // resource and power controls
   output logic      [NRES-1:0]  res_en,
   output logic                  reg_en,
   output logic                  main_clk_en,
   output logic                  core_pwr_en,
   output logic      [1:0]       clk_rate,
   output logic                  ret_save,
   output logic                  ret_restore,
   output logic      [2:0]       pm_mode
);

   ////////////////////////////////////////////////////////////////////////////
   // storage

   logic [NRES-1:0]   resource_on_flag;
   logic [NRES-1:0]   resource_in_transition_flag;
   logic [TW-1:0]     tmr_q      [NRES];
   logic [TW-1:0]     ton_q      [NRES];
   logic [TW-1:0]     toff_q     [NRES];
   logic [NRES-1:0]   dep_q      [NRES];
   logic [NRES-1:0]   clkmap_q   [NCLK];
   logic [RTW-1:0]    rtmr_cnt_q [NTMR];
   logic [NRES-1:0]   rtmr_mask_q[NTMR];
   logic [NRES-1:0]   minimum_resource_mask;
   logic [7:0]        sel_q;
   logic [1:0]        rate_cfg_q;
   logic [31:0]       lp_cnt_q;
   logic              lp_tick_q;
   prs_mode_t         mode_q;
   logic [31:0]       rdata_q;
   logic              reg_en_q;
   logic              main_clk_en_q;
   logic              core_pwr_en_q;
   logic [1:0]        clk_rate_q;
   logic              ret_save_q;
   logic              ret_restore_q;

   // regulator pin low acts as a held reset on every flip-flop but the tables and the read data
   logic              hold;
   assign hold = ~reg_on;

   ////////////////////////////////////////////////////////////////////////////
   // dependency helpers

   // a powered resource holds up every resource that it depends on;
   // a process, not a function in an assign, so table writes are seen
   logic [NRES-1:0] live_dep;

   always_comb
   begin
      live_dep = '0;
      for (int p = 0; p < NRES; p++)
      begin
         for (int q = 0; q < NRES; q++)
         begin
            if (dep_q[q][p] && (resource_on_flag[q] || resource_in_transition_flag[q]))
            begin
               live_dep[p] = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // low-power tick: divider gives one pulse per low-power clock period

   logic lp_wrap;
   assign lp_wrap = (lp_cnt_q == 32'(LP_DIV - 1));

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         lp_cnt_q  <= 32'h0;
         lp_tick_q <= 1'b0;
      end
      else
      begin
         lp_cnt_q  <= (lp_wrap || hold) ? 32'h0 : lp_cnt_q + 32'h1;
         lp_tick_q <= lp_wrap && !hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // request set

   logic [NRES-1:0] clk_res;
   logic [NRES-1:0] tmr_res;
   logic [NRES-1:0] raw_req;
   logic [NRES-1:0] required;
   logic [NRES-1:0] dep_ok;
   logic [NRES-1:0] start_up;
   logic [NRES-1:0] start_dn;
   logic [NTMR-1:0] rtmr_expire;

   always_comb
   begin
      clk_res = '0;
      tmr_res = '0;
      for (int c = 0; c < NCLK; c++)
      begin
         if (clk_req[c])
         begin
            clk_res = clk_res | clkmap_q[c];
         end
      end
      for (int t = 0; t < NTMR; t++)
      begin
         if (rtmr_cnt_q[t] != '0)
         begin
            tmr_res = tmr_res | rtmr_mask_q[t];
         end
      end
   end

   assign raw_req  = clk_res | minimum_resource_mask | tmr_res;

   // closure through the dependency table; NRES passes cover any chain
   always_comb
   begin
      required = raw_req;
      for (int n = 0; n < NRES; n++)
      begin
         for (int k = 0; k < NRES; k++)
         begin
            if (required[k])
            begin
               required = required | dep_q[k];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-resource state machine

   wire logic [NRES-1:0] settled_on = resource_on_flag & ~resource_in_transition_flag;

   generate
      for (genvar i = 0; i < NRES; i++)
      begin : g_res
         // a transition in progress is never interrupted
         assign dep_ok[i]   = ((dep_q[i] & ~settled_on) == '0);
         assign start_up[i] = !resource_on_flag[i] && !resource_in_transition_flag[i] &&
                              required[i] && dep_ok[i];
         assign start_dn[i] = resource_on_flag[i] && !resource_in_transition_flag[i] &&
                              !required[i] && !live_dep[i];

         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               resource_on_flag[i]            <= 1'b0;
               resource_in_transition_flag[i] <= 1'b0;
               tmr_q[i]                       <= '0;
            end
            else if (hold)
            begin
               resource_on_flag[i]            <= 1'b0;
               resource_in_transition_flag[i] <= 1'b0;
               tmr_q[i]                       <= '0;
            end
            else if (lp_tick_q)
            begin
               if (tmr_q[i] != '0)
               begin
                  tmr_q[i] <= tmr_q[i] - TW'(1);
                  if (tmr_q[i] == TW'(1))
                  begin
                     resource_in_transition_flag[i] <= 1'b0;
                     resource_on_flag[i]            <= !resource_on_flag[i];
                  end
               end
               else if (start_up[i])
               begin
                  if (ton_q[i] == '0)
                  begin
                     resource_on_flag[i] <= 1'b1;
                  end
                  else
                  begin
                     resource_in_transition_flag[i] <= 1'b1;
                     tmr_q[i]                       <= ton_q[i];
                  end
               end
               else if (start_dn[i])
               begin
                  if (toff_q[i] == '0)
                  begin
                     resource_on_flag[i] <= 1'b0;
                  end
                  else
                  begin
                     resource_in_transition_flag[i] <= 1'b1;
                     tmr_q[i]                       <= toff_q[i];
                  end
               end
            end
         end

         timer_zero_a: assert property (@(posedge mclk) disable iff (rst)
            (tmr_q[i] == '0) == !resource_in_transition_flag[i])
            else $error("timer and transition flag disagree");

         expire_toggle_a: assert property (@(posedge mclk) disable iff (rst || hold)
            lp_tick_q && tmr_q[i] == TW'(1) |=>
               !resource_in_transition_flag[i] &&
               resource_on_flag[i] != $past(resource_on_flag[i]))
            else $error("expiring timer did not finish transition");

         load_on_a: assert property (@(posedge mclk) disable iff (rst || hold)
            lp_tick_q && tmr_q[i] == '0 && start_up[i] && ton_q[i] != '0 |=>
               resource_in_transition_flag[i] && tmr_q[i] == $past(ton_q[i]))
            else $error("enable delay not loaded");

         fast_on_a: assert property (@(posedge mclk) disable iff (rst || hold)
            lp_tick_q && start_up[i] && ton_q[i] == '0 |=>
               resource_on_flag[i] && !resource_in_transition_flag[i])
            else $error("zero enable delay did not switch on");

         fast_off_a: assert property (@(posedge mclk) disable iff (rst || hold)
            lp_tick_q && start_dn[i] && toff_q[i] == '0 |=>
               !resource_on_flag[i] && !resource_in_transition_flag[i])
            else $error("zero disable delay did not switch off");

         down_guard_a: assert property (@(posedge mclk) disable iff (rst || hold)
            $rose(resource_in_transition_flag[i]) && $past(resource_on_flag[i]) |->
               $past(!required[i] && !live_dep[i]))
            else $error("disable started on a needed resource");

         up_guard_a: assert property (@(posedge mclk) disable iff (rst || hold)
            $rose(resource_on_flag[i]) && !resource_in_transition_flag[i] &&
               !$past(resource_in_transition_flag[i]) |->
               $past(required[i] && dep_ok[i]))
            else $error("enable started without dependencies");

         dep_closed_a: assert property (@(posedge mclk) disable iff (rst)
            required[i] |-> (dep_q[i] & ~required) == '0)
            else $error("required set not closed over dependencies");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // request timers count down on the low-power tick; a write reloads

   wire logic sel_tmr = (sel_q < 8'(NTMR));
   wire logic wr_rcnt = wr && addr == `PRS_OFF_RTMR_CNT && sel_tmr;

   generate
      for (genvar t = 0; t < NTMR; t++)
      begin : g_rtmr
         assign rtmr_expire[t] = lp_tick_q && rtmr_cnt_q[t] == RTW'(1);
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               rtmr_cnt_q[t] <= '0;
            end
            else if (hold)
            begin
               rtmr_cnt_q[t] <= '0;
            end
            else if (wr_rcnt && sel_q == 8'(t))
            begin
               rtmr_cnt_q[t] <= wdata[RTW-1:0];
            end
            else if (lp_tick_q && rtmr_cnt_q[t] != '0)
            begin
               rtmr_cnt_q[t] <= rtmr_cnt_q[t] - RTW'(1);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   wire logic       wr_ctrl = wr && addr == `PRS_OFF_CTRL;
   wire logic [1:0] cmd     = wr_ctrl ? wdata[`PRS_CTRL_CMD_LSB +: 2] : `PRS_CMD_NONE;
   wire logic       sel_res = (sel_q < 8'(NRES));
   wire logic       sel_clk = (sel_q < 8'(NCLK));

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         minimum_resource_mask <= NRES'(`PRS_RST_MINMASK);
         sel_q                 <= 8'h0;
         rate_cfg_q            <= `PRS_RST_RATE;
      end
      else if (hold)
      begin
         minimum_resource_mask <= NRES'(`PRS_RST_MINMASK);
         sel_q                 <= 8'h0;
         rate_cfg_q            <= `PRS_RST_RATE;
      end
      else
      begin
         if (wr && addr == `PRS_OFF_MINMASK)
         begin
            minimum_resource_mask <= wdata[NRES-1:0];
         end
         if (wr && addr == `PRS_OFF_SEL)
         begin
            sel_q <= wdata[7:0];
         end
         if (wr_ctrl)
         begin
            rate_cfg_q <= wdata[`PRS_CTRL_RATE_LSB +: 2];
         end
      end
   end

   // tables survive the regulator pin hold; only the power-on reset clears them
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int k = 0; k < NRES; k++)
         begin
            ton_q[k]  <= '0;
            toff_q[k] <= '0;
            dep_q[k]  <= '0;
         end
         for (int k = 0; k < NCLK; k++)
         begin
            clkmap_q[k] <= '0;
         end
         for (int k = 0; k < NTMR; k++)
         begin
            rtmr_mask_q[k] <= '0;
         end
      end
      else if (wr)
      begin
         if (sel_res && addr == `PRS_OFF_TIME_ON)
         begin
            ton_q[sel_q[$clog2(NRES)-1:0]] <= wdata[TW-1:0];
         end
         if (sel_res && addr == `PRS_OFF_TIME_OFF)
         begin
            toff_q[sel_q[$clog2(NRES)-1:0]] <= wdata[TW-1:0];
         end
         if (sel_res && addr == `PRS_OFF_DEPMASK)
         begin
            dep_q[sel_q[$clog2(NRES)-1:0]] <= wdata[NRES-1:0];
         end
         if (sel_clk && addr == `PRS_OFF_CLKMAP)
         begin
            clkmap_q[sel_q[$clog2(NCLK)-1:0]] <= wdata[NRES-1:0];
         end
         if (sel_tmr && addr == `PRS_OFF_RTMR_MASK)
         begin
            rtmr_mask_q[sel_q[$clog2(NTMR)-1:0]] <= wdata[NRES-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power modes

   wire logic wake_deep = wake_irq || usb_resume || (|rtmr_expire);
   wire logic wake_doze = wake_deep || (|clk_req);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mode_q <= PM_ACTIVE;
      end
      else if (hold)
      begin
         mode_q <= PM_ACTIVE;
      end
      else
      begin
         unique case (mode_q)
            PM_ACTIVE:
               if (cmd == `PRS_CMD_DOZE)
               begin
                  mode_q <= PM_DOZE;
               end
               else if (cmd == `PRS_CMD_DEEP)
               begin
                  mode_q <= PM_SAVE;
               end
               else if (cmd == `PRS_CMD_DOWN)
               begin
                  mode_q <= PM_DOWN;
               end
            PM_DOZE:    mode_q <= wake_doze ? PM_ACTIVE : PM_DOZE;
            PM_SAVE:    mode_q <= PM_DEEP;
            PM_DEEP:    mode_q <= wake_deep ? PM_RESTORE : PM_DEEP;
            PM_RESTORE: mode_q <= PM_ACTIVE;
            PM_DOWN:    mode_q <= PM_DOWN;
            default:    mode_q <= PM_ACTIVE;
         endcase
      end
   end

   // outputs follow the mode one cycle later, each from its own flop
   wire prs_mode_t  mode_n  = mode_q;
   wire logic [1:0] rate_n  = (mode_n == PM_ACTIVE && |clk_req) ? rate_cfg_q : 2'h0;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reg_en_q      <= 1'b0;
         main_clk_en_q <= 1'b0;
         core_pwr_en_q <= 1'b0;
         clk_rate_q    <= 2'h0;
         ret_save_q    <= 1'b0;
         ret_restore_q <= 1'b0;
      end
      else
      begin
         reg_en_q      <= !hold && mode_n != PM_DOWN;
         main_clk_en_q <= !hold && mode_n == PM_ACTIVE;
         core_pwr_en_q <= !hold && mode_n != PM_DEEP && mode_n != PM_DOWN;
         clk_rate_q    <= hold ? 2'h0 : rate_n;
         ret_save_q    <= !hold && mode_n == PM_SAVE;
         ret_restore_q <= !hold && mode_n == PM_RESTORE;
      end
   end

   doze_clock_a: assert property (@(posedge mclk) disable iff (rst)
      mode_q == PM_DOZE |=> !main_clk_en_q)
      else $error("main clock running in doze");

   deep_save_a: assert property (@(posedge mclk) disable iff (rst)
      mode_q == PM_DEEP && $past(mode_q) != PM_DEEP |-> $past(mode_q) == PM_SAVE ##1 !core_pwr_en_q)
      else $error("deep sleep entered without save");

   down_stays_a: assert property (@(posedge mclk) disable iff (rst)
      mode_q == PM_DOWN && reg_on |=> mode_q == PM_DOWN ##1 !reg_en_q)
      else $error("power down left without regulator cycling");

   regon_hold_a: assert property (@(posedge mclk) disable iff (rst)
      !reg_on |=> resource_on_flag == '0 && !reg_en_q)
      else $error("resources alive while regulator pin low");

   req_cover_a: assert property (@(posedge mclk) disable iff (rst)
      (minimum_resource_mask & ~required) == '0 && (clk_res & ~required) == '0)
      else $error("required set misses a request");

   ////////////////////////////////////////////////////////////////////////////
   // read port: data in the cycle after the strobe, unmapped reads zero

   prs_res_state_t st0;
   assign st0 = prs_res_state_t'({resource_in_transition_flag[0], resource_on_flag[0]});

   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0;
      unique case (addr)
         `PRS_OFF_CTRL:      rd_mux = {28'h0, rate_cfg_q, 2'h0};
         `PRS_OFF_MINMASK:   rd_mux = 32'(minimum_resource_mask);
         `PRS_OFF_STATUS:    rd_mux = {27'h0, st0, mode_q};
         `PRS_OFF_RES_ON:    rd_mux = 32'(resource_on_flag);
         `PRS_OFF_RES_PEND:  rd_mux = 32'(resource_in_transition_flag);
         `PRS_OFF_REQUIRED:  rd_mux = 32'(required);
         `PRS_OFF_SEL:       rd_mux = {24'h0, sel_q};
         `PRS_OFF_TIME_ON:   rd_mux = sel_res ? 32'(ton_q[sel_q[$clog2(NRES)-1:0]]) : 32'h0;
         `PRS_OFF_TIME_OFF:  rd_mux = sel_res ? 32'(toff_q[sel_q[$clog2(NRES)-1:0]]) : 32'h0;
         `PRS_OFF_DEPMASK:   rd_mux = sel_res ? 32'(dep_q[sel_q[$clog2(NRES)-1:0]]) : 32'h0;
         `PRS_OFF_CLKMAP:    rd_mux = sel_clk ? 32'(clkmap_q[sel_q[$clog2(NCLK)-1:0]]) : 32'h0;
         `PRS_OFF_RTMR_CNT:  rd_mux = sel_tmr ? 32'(rtmr_cnt_q[sel_q[$clog2(NTMR)-1:0]]) : 32'h0;
         `PRS_OFF_RTMR_MASK: rd_mux = sel_tmr ? 32'(rtmr_mask_q[sel_q[$clog2(NTMR)-1:0]]) : 32'h0;
         default:            rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 32'h0;
      end
      else
      begin
         rdata_q <= rd ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign rdata       = rdata_q;
   assign res_en      = resource_on_flag;
   assign reg_en      = reg_en_q;
   assign main_clk_en = main_clk_en_q;
   assign core_pwr_en = core_pwr_en_q;
   assign clk_rate    = clk_rate_q;
   assign ret_save    = ret_save_q;
   assign ret_restore = ret_restore_q;
   assign pm_mode     = mode_q;

endmodule : prs_sequencer

/* prs_partner.sv */
// prs_partner.sv: external power-on logic that drives the regulator pin.
// assumes the bench asks for a power cycle with a one-cycle request.
`timescale 1ns/1ps
module prs_partner
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // bench request
   input  wire logic cyc_req,
   // regulator pin
   output logic      reg_on
);
   logic [3:0] low_q;
   // the device cannot leave power down alone, so the pin is pulled low a while
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst) low_q <= 4'h0;
      else if (cyc_req) low_q <= 4'h8;
      else if (low_q != 4'h0) low_q <= low_q - 4'h1;
   end
   assign reg_on = (low_q == 4'h0);
endmodule : prs_partner

/* prs_sequencer_tb_top.sv */
// prs_sequencer_tb_top.sv: self-checking bench of the resource sequencer.
// assumes the register map of prs_defs.svh and a tick shortened to 4 cycles.
`timescale 1ns/1ps
`include "prs_defs.svh"
module prs_sequencer_tb_top
   import prs_pkg::*;
;
   logic        mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cyc_req = 1'b0;
   logic        wake_irq = 1'b0, usb_resume = 1'b0, reg_on;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0]  clk_req = 4'h0;
   logic [7:0]  res_en;
   logic        reg_en, main_clk_en, core_pwr_en, ret_save, ret_restore;
   logic [1:0]  clk_rate;
   logic [2:0]  pm_mode;
   int          fails = 0, n_checks = 0;
   wire  [4:0]  obs = {ret_restore, ret_save, core_pwr_en, main_clk_en, reg_en};
   always #5 mclk = ~mclk;
   prs_sequencer #(.LP_DIV(4)) u_prs_sequencer (.mclk(mclk), .rst(rst), .reg_on(reg_on),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clk_req(clk_req),
      .wake_irq(wake_irq), .usb_resume(usb_resume), .res_en(res_en), .reg_en(reg_en),
      .main_clk_en(main_clk_en), .core_pwr_en(core_pwr_en), .clk_rate(clk_rate),
      .ret_save(ret_save), .ret_restore(ret_restore), .pm_mode(pm_mode));
   prs_partner u_prs_partner (.mclk(mclk), .rst(rst), .cyc_req(cyc_req), .reg_on(reg_on));
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      if (fails == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data are taken in the single cycle that they stand
   task rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg
   task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      for (int i = 0; i < 60; i++)
      begin
         rd_reg(a, d);
         if ((d & m) === e) break;
      end
      chk(d & m, e);
      if (fails != 0) finish_test();
   endtask : poll
   // looks before the first wait, so a one-cycle pulse is not missed
   task wait_obs(input int idx, input logic v);
      for (int i = 0; i < 200; i++)
      begin
         #1;
         if (obs[idx] === v) break;
         @(posedge mclk);
      end
      chk({31'h0, obs[idx]}, {31'h0, v});
      if (fails != 0) finish_test();
   endtask : wait_obs
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(`PRS_OFF_MINMASK, d);
      chk(d, `PRS_RST_MINMASK);
      chk({24'h0, res_en}, 32'h0);
      poll(`PRS_OFF_RES_ON, 32'hff, 32'h1);
      poll(`PRS_OFF_STATUS, 32'h18, 32'h08);
      wr_reg(`PRS_OFF_SEL, 32'h1);
      wr_reg(`PRS_OFF_TIME_ON, 32'h3);
      wr_reg(`PRS_OFF_TIME_OFF, 32'h2);
      wr_reg(`PRS_OFF_DEPMASK, 32'h1);
      wr_reg(`PRS_OFF_MINMASK, 32'h2);
      poll(`PRS_OFF_REQUIRED, 32'hff, 32'h3);
      poll(`PRS_OFF_RES_PEND, 32'h2, 32'h2);
      chk({31'h0, res_en[1]}, 32'h0);
      poll(`PRS_OFF_RES_ON, 32'h3, 32'h3);
      poll(`PRS_OFF_RES_PEND, 32'h2, 32'h0);
      wr_reg(`PRS_OFF_SEL, 32'h2);
      wr_reg(`PRS_OFF_CLKMAP, 32'h10);
      @(posedge mclk);
      clk_req <= 4'h4;
      poll(`PRS_OFF_REQUIRED, 32'h10, 32'h10);
      poll(`PRS_OFF_RES_ON, 32'h10, 32'h10);
      chk({30'h0, clk_rate}, {30'h0, `PRS_RST_RATE});
      wr_reg(`PRS_OFF_SEL, 32'h0);
      wr_reg(`PRS_OFF_RTMR_MASK, 32'h20);
      wr_reg(`PRS_OFF_RTMR_CNT, 32'h5);
      poll(`PRS_OFF_REQUIRED, 32'h20, 32'h20);
      poll(`PRS_OFF_REQUIRED, 32'h20, 32'h0);
      // nothing requested: resource 0 must wait for its dependent to finish
      @(posedge mclk);
      clk_req <= 4'h0;
      wr_reg(`PRS_OFF_MINMASK, 32'h0);
      poll(`PRS_OFF_RES_PEND, 32'h2, 32'h2);
      rd_reg(`PRS_OFF_RES_ON, d);
      chk(d & 32'h3, 32'h3);
      poll(`PRS_OFF_RES_ON, 32'hff, 32'h0);
      wr_reg(`PRS_OFF_CTRL, 32'hd);
      wait_obs(1, 1'b0);
      chk({29'h0, pm_mode}, {29'h0, PM_DOZE});
      @(posedge mclk);
      wake_irq <= 1'b1;
      wait_obs(1, 1'b1);
      @(posedge mclk);
      wake_irq <= 1'b0;
      wr_reg(`PRS_OFF_CTRL, 32'he);
      wait_obs(3, 1'b1);
      wait_obs(2, 1'b0);
      @(posedge mclk);
      usb_resume <= 1'b1;
      wait_obs(4, 1'b1);
      @(posedge mclk);
      usb_resume <= 1'b0;
      wait_obs(2, 1'b1);
      wr_reg(`PRS_OFF_CTRL, 32'hf);
      wait_obs(0, 1'b0);
      repeat (40) @(posedge mclk);
      #1;
      chk({29'h0, pm_mode}, {29'h0, PM_DOWN});
      @(posedge mclk);
      cyc_req <= 1'b1;
      @(posedge mclk);
      cyc_req <= 1'b0;
      repeat (12) @(posedge mclk);
      wait_obs(0, 1'b1);
      rd_reg(`PRS_OFF_MINMASK, d);
      chk(d, `PRS_RST_MINMASK);
      finish_test();
   end
endmodule : prs_sequencer_tb_top
